// File: i2c_master_model.sv
// Behavioural two-wire bus master that drives the slave's pins.
`timescale 1ns/1ps
module i2c_master_model #(
    parameter real Q = 31.25
)(
    input wire logic scl_bus,
    input wire logic sda_bus,
    output logic scl_drv,
    output logic sda_drv,
    output logic stuck
);
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
        stuck = 1'b0;
    end
    ////////////////////////////////////////
    // master clock, stretch tolerated.
    task automatic scl_hi();
        int n;
        scl_drv <= 1'b1;
        n = 0;
        #1;
        while (scl_bus !== 1'b1 && n < 50000) begin
            #1;
            n++;
        end
        if (n >= 50000) stuck <= 1'b1;
    endtask
    task automatic start();
        sda_drv <= 1'b1;
        #(Q);
        scl_hi();
        #(Q);
        sda_drv <= 1'b0;
        #(Q);
        scl_drv <= 1'b0;
        #(Q);
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        #(Q);
        scl_hi();
        #(Q);
        sda_drv <= 1'b1;
        #(Q);
    endtask
    // data moves only while the clock is low.
    task automatic bit_io(input logic b, output logic r);
        sda_drv <= b;
        #(Q);
        scl_hi();
        #(Q);
        r = sda_bus;
        #(Q);
        scl_drv <= 1'b0;
        #(Q);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic rbyte(output logic [7:0] b, input logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nak, r);
    endtask
endmodule

// File: stream_if.sv
// Valid/ready word stream into and out of the link engine's write queue.
`timescale 1ns/1ps
interface stream_if #(
    parameter int WIDTH = 8
) ();
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: tb.sv
// Self-checking bench for the touch controller two-wire slave.
`timescale 1ns/1ps
module tb;
    import touch_i2c_pkg::*;
    logic mclk, rst_n, addr_load, nv_busy, wr_ready, scl_drv, sda_drv, m_stuck;
    logic scl_val, scl_oe_n, sda_val, sda_oe_n, wr_valid, wr_factory, rd_strobe, a;
    logic [6:0] addr_new;
    logic [7:0] wr_addr, wr_data, rd_addr;
    int errors, n_tests;
    // Pull-ups: a line is low when any party pulls it.
    wire scl_bus = scl_drv & (scl_oe_n | scl_val);
    wire sda_bus = sda_drv & (sda_oe_n | sda_val);
    // The core answers reads combinationally with a pattern of the address.
    wire [7:0] rd_data = rd_addr ^ 8'h5a;
    touch_i2c_slave #(.FIFO_DEPTH(8)) dut_u (.mclk(mclk), .rst_n(rst_n), .scl_line(scl_bus),
        .scl_val(scl_val), .scl_oe_n(scl_oe_n), .sda_line(sda_bus), .sda_val(sda_val),
        .sda_oe_n(sda_oe_n), .addr_load(addr_load), .addr_new(addr_new), .nv_busy(nv_busy),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_factory(wr_factory),
        .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_strobe(rd_strobe), .rd_data(rd_data));
    i2c_master_model m_u (.scl_bus(scl_bus), .sda_bus(sda_bus), .scl_drv(scl_drv),
        .sda_drv(sda_drv), .stuck(m_stuck));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic nak);
        m_u.wbyte(b, a);
        chk({7'h0, a}, {7'h0, nak});
    endtask
    task automatic take(input logic [7:0] ea, input logic [7:0] ed, input logic ef);
        int n;
        n = 0;
        while (wr_valid !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 100) begin
            errors++;
            end_sim();
        end
        chk(wr_addr, ea); // register address offered.
        chk(wr_data, ed); // value offered.
        chk({7'h0, wr_factory}, {7'h0, ef}); // factory flag.
        @(posedge mclk);
        wr_ready <= 1'b1;
        @(posedge mclk);
        wr_ready <= 1'b0;
        @(posedge mclk);
        #1;
        chk({7'h0, wr_valid}, 8'h00); // word taken once.
    endtask
    task automatic wframe(input logic [7:0] r, input logic [7:0] v, input logic [7:0] s, input logic ok);
        m_u.start();
        send(8'he6, 1'b0); // address with write direction.
        send(8'h55, 1'b0); // first guard.
        send(8'haa, 1'b0); // second guard.
        send(r, 1'b0); // register byte.
        send(v, 1'b0); // value byte.
        send(s, !ok); // checksum judged.
        chk({7'h0, wr_valid}, 8'h00); // nothing before the stop.
        m_u.stop();
    endtask
    task automatic refuse(input logic [7:0] ab);
        m_u.start();
        send(ab, 1'b1); // address byte refused.
        m_u.stop();
    endtask
    ////////////////////////////////////////
    task automatic t_write();
        wframe(8'h12, 8'h34, 8'hd9, 1'b1);
        refuse(8'he6); // pending write blocks the bus.
        take(8'h12, 8'h34, 1'b0);
        wframe(8'h00, 8'hff, 8'h00, 1'b1);
        take(8'h00, 8'hff, 1'b1);
    endtask
    task automatic t_bad();
        wframe(8'h12, 8'h34, 8'hd8, 1'b0);
        m_u.start();
        send(8'he6, 1'b0); // start of a cut frame.
        send(8'h55, 1'b0); // guard.
        send(8'hab, 1'b1); // wrong second guard.
        m_u.stop();
        m_u.start();
        send(8'he6, 1'b0); // fresh frame after stop.
        send(8'h55, 1'b0); // guard.
        m_u.stop();
        repeat (100) @(posedge mclk);
        chk({7'h0, wr_valid}, 8'h00); // aborted frames store nothing.
    endtask
    task automatic t_read();
        logic [7:0] b;
        m_u.start();
        send(8'he6, 1'b0); // write address first.
        send(8'h80, 1'b0); // register byte.
        m_u.start();
        send(8'he7, 1'b0); // read direction accepted.
        m_u.rbyte(b, 1'b0);
        chk(b, 8'h80 ^ 8'h5a); // first byte at the requested place.
        m_u.rbyte(b, 1'b1);
        chk(b, 8'h81 ^ 8'h5a); // address advanced by one.
        chk(rd_addr, 8'h82); // address after two bytes.
        m_u.stop();
        m_u.start();
        send(8'he7, 1'b0); // checksum read accepted.
        m_u.rbyte(b, 1'b1);
        chk(b, 8'h80 ^ 8'h81); // xor of the previous bytes.
        m_u.stop();
    endtask
    task automatic t_addr();
        refuse(8'h00); // general call.
        refuse(8'h24); // foreign address.
        refuse(8'hf0); // extended addressing prefix.
        @(posedge mclk);
        addr_load <= 1'b1;
        addr_new <= 7'h21;
        @(posedge mclk);
        addr_load <= 1'b0;
        refuse(8'he6); // old address dropped.
        m_u.start();
        send(8'h42, 1'b0); // new address answered.
        m_u.stop();
        @(posedge mclk);
        nv_busy <= 1'b1;
        addr_load <= 1'b1;
        addr_new <= 7'h73;
        @(posedge mclk);
        addr_load <= 1'b0;
        refuse(8'he6); // refused while storing.
        @(posedge mclk);
        nv_busy <= 1'b0;
    endtask
    ////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        addr_load = 1'b0;
        addr_new = 7'h00;
        nv_busy = 1'b0;
        wr_ready = 1'b0;
        errors = 0;
        n_tests = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        t_write();
        t_bad();
        t_read();
        t_addr();
        end_sim();
    end
    // A clock line held low for too long ends the run.
    always @(posedge m_stuck) begin
        errors++;
        end_sim();
    end
endmodule

// File: touch_i2c_pkg.sv
// Shared constants and types for the touch controller two-wire slave front end.
package touch_i2c_pkg;

    // Slave address after reset: 1110011.
    localparam logic [6:0] ADDR_RESET = 7'h73;
    localparam logic [6:0] GCALL_ADDR = 7'h00;
    // Upper five bits 11110 of an address byte introduce extended addressing.
    localparam logic [4:0] TENBIT_PFX = 5'h1e;

    localparam logic [7:0] GUARD_FIRST = 8'h55;
    localparam logic [7:0] GUARD_SECOND = 8'haa;
    localparam logic [7:0] FACTORY_REG = 8'h00;
    localparam logic [7:0] FACTORY_VAL = 8'hff;
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] RD_ADDR_RESET = 8'h00;
    localparam logic [7:0] SUM_RESET = 8'h00;

    // Link rates and the sampling margin they leave at the core clock.
    localparam int MCLK_KHZ = 250000;
    localparam int SCL_STD_KHZ = 100;
    localparam int SCL_FAST_KHZ = 400;
    localparam int FAST_HALF_CYCLES = MCLK_KHZ / (2 * SCL_FAST_KHZ);
    localparam int SYNC_LAT_CYCLES = 3;

    // Write queue: one word is {factory flag, register, value}.
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int WR_WORD_W = 17;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_HOLD = 3'b011,
        ST_TX = 3'b100,
        ST_MACK = 3'b101,
        ST_SR = 3'b110
    } link_st_t;

    typedef enum logic [3:0] {
        PH_ADDR = 4'b0000,
        PH_B1 = 4'b0001,
        PH_G2 = 4'b0010,
        PH_WREG = 4'b0011,
        PH_WVAL = 4'b0100,
        PH_WSUM = 4'b0101,
        PH_WDONE = 4'b0110,
        PH_SR = 4'b0111,
        PH_RD = 4'b1000,
        PH_CK = 4'b1001,
        PH_CKDONE = 4'b1010
    } cmd_ph_t;

endpackage

// File: touch_i2c_slave.sv
// Two-wire serial slave with protected register writes and checksummed reads.
//
// Operation
// - Works at 100 kHz and 400 kHz.
// - Seven-bit addresses only, extended addressing ignored.
// - First byte after Start: address plus direction.
// - Address programmable, resets to 1110011.
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
// - Stop returns the whole interface to idle.
// - Data changes only while clock is low.
// - Accepted bytes acknowledged on the ninth clock.
// - General call and foreign addresses not acknowledged.
// - No acknowledge while stored writes are pending.
// - Start collision ignored, other collisions reset.
// - Repeated Start collision: data low or early clock.
// - Clock held low until write can be stored.
// - Malformed or interrupted commands abort without effect.
// - Write frame: guards, register, value, XOR checksum.
// - Value FF to register 00 restores factory settings.
// - Read frame: register, Repeated Start, read address.
// - Next read address returns XOR of previous read.
// - Read address advances after each sent byte.
// - Write released only after closing Stop.
// - Bad checksum discards the write frame.
// - Undefined command releases data, waits for Start.
`timescale 1ns/1ps
module touch_i2c_slave #(
    parameter int FIFO_DEPTH = touch_i2c_pkg::FIFO_DEPTH_DEF
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_line,
    output logic scl_val,
    output logic scl_oe_n,
    input wire logic sda_line,
    output logic sda_val,
    output logic sda_oe_n,
    input wire logic addr_load,
    input wire logic [6:0] addr_new,
    input wire logic nv_busy,
    output logic wr_valid,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic wr_factory,
    input wire logic wr_ready,
    output logic [7:0] rd_addr,
    output logic rd_strobe,
    input wire logic [7:0] rd_data
);
    import touch_i2c_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    link_st_t state_r;
    cmd_ph_t ph_r;
    cmd_ph_t ph_dec_w;
    logic [3:0] bitcnt_r;
    logic [7:0] shift_r, tx_r, sum_r, ck_r, wreg_r, wval_r, rd_addr_r;
    logic [6:0] own_addr_r;
    logic ack_r, mack_r, sr_ok_r, ck_valid_r, sent_r;
    logic sda_oe_n_r, scl_oe_n_r, rd_strobe_r;
    logic wr_valid_r, wr_factory_r;
    logic [7:0] wr_addr_r, wr_data_r;
    logic acc_w;

    stream_if #(.WIDTH(WR_WORD_W)) fill_s ();
    stream_if #(.WIDTH(WR_WORD_W)) drain_s ();

    word_fifo #(.WIDTH(WR_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(mclk),
        .rst_n(rst_n),
        .fill(fill_s),
        .drain(drain_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Line events, all taken from the second and third synchroniser stages.
    wire scl_rise = scl_s2_r & ~scl_s3_r;
    wire scl_fall = ~scl_s2_r & scl_s3_r;
    wire start_det = scl_s2_r & scl_s3_r & ~sda_s2_r & sda_s3_r;
    wire stop_det = scl_s2_r & scl_s3_r & sda_s2_r & ~sda_s3_r;
    wire byte_done = (state_r == ST_RX) && scl_fall && (bitcnt_r == BITS_PER_BYTE);
    wire is_gcall = (shift_r[7:1] == GCALL_ADDR);
    wire is_tenbit = (shift_r[7:3] == TENBIT_PFX);
    wire addr_hit_w = (shift_r[7:1] == own_addr_r) && !is_gcall && !is_tenbit;
    wire busy_w = nv_busy | wr_valid_r | drain_s.valid;
    wire wr_is_factory = (wreg_r == FACTORY_REG) && (wval_r == FACTORY_VAL);
    wire rd_phase = (ph_r == PH_RD) || (ph_r == PH_CK);
    wire hold_need = (ph_r == PH_WDONE) && !fill_s.ready;
    wire load_w = ((state_r == ST_ACK) && scl_fall && ack_r && rd_phase)
        || ((state_r == ST_MACK) && scl_fall && mack_r);
    wire [7:0] tx_load_w = (ph_r == PH_RD) ? rd_data : ((ph_r == PH_CK) ? ck_r : IDLE_BYTE);

    assign fill_s.valid = stop_det && (ph_r == PH_WDONE);
    assign fill_s.data = {wr_is_factory, wreg_r, wval_r};
    assign drain_s.ready = ~wr_valid_r | wr_ready;

    assign scl_val = 1'b0;
    assign sda_val = 1'b0;
    assign scl_oe_n = scl_oe_n_r;
    assign sda_oe_n = sda_oe_n_r;
    assign wr_valid = wr_valid_r;
    assign wr_addr = wr_addr_r;
    assign wr_data = wr_data_r;
    assign wr_factory = wr_factory_r;
    assign rd_addr = rd_addr_r;
    assign rd_strobe = rd_strobe_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte acceptance per command phase; a refused byte ends the command.
    always_comb begin
        acc_w = 1'b0;
        ph_dec_w = ph_r;
        case (ph_r)
            PH_ADDR: begin
                if (addr_hit_w && !busy_w) begin
                    if (!shift_r[0]) begin
                        acc_w = 1'b1;
                        ph_dec_w = PH_B1;
                    end else if (sr_ok_r) begin
                        acc_w = 1'b1;
                        ph_dec_w = PH_RD;
                    end else if (ck_valid_r) begin
                        acc_w = 1'b1;
                        ph_dec_w = PH_CK;
                    end
                end
            end
            PH_B1: begin
                acc_w = 1'b1;
                ph_dec_w = (shift_r == GUARD_FIRST) ? PH_G2 : PH_SR;
            end
            PH_G2: begin
                acc_w = (shift_r == GUARD_SECOND);
                ph_dec_w = PH_WREG;
            end
            PH_WREG: begin
                acc_w = 1'b1;
                ph_dec_w = PH_WVAL;
            end
            PH_WVAL: begin
                acc_w = 1'b1;
                ph_dec_w = PH_WSUM;
            end
            PH_WSUM: begin
                acc_w = (shift_r == sum_r);
                ph_dec_w = PH_WDONE;
            end
            default: begin
                acc_w = 1'b0;
                ph_dec_w = ph_r;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // synchroniser margin
    // Three core cycles of latency against 312 per fast-mode half period leave ample room.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
            {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
        end else begin
            {scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_line, scl_s1_r, scl_s2_r};
            {sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_line, sda_s1_r, sda_s2_r};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_valid_r <= 1'b0;
            {wr_factory_r, wr_addr_r, wr_data_r} <= '0;
            own_addr_r <= ADDR_RESET;
        end else begin
            if (drain_s.ready) begin
                wr_valid_r <= drain_s.valid;
                {wr_factory_r, wr_addr_r, wr_data_r} <= drain_s.data;
            end
            if (addr_load) begin
                own_addr_r <= addr_new;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link engine. Stop outranks Start, and both outrank the bit-level states.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            ph_r <= PH_ADDR;
            bitcnt_r <= 4'h0;
            {shift_r, tx_r, wreg_r, wval_r} <= '0;
            sum_r <= SUM_RESET;
            ck_r <= SUM_RESET;
            rd_addr_r <= RD_ADDR_RESET;
            {ack_r, mack_r, sr_ok_r, ck_valid_r, sent_r, rd_strobe_r} <= '0;
            sda_oe_n_r <= 1'b1;
            scl_oe_n_r <= 1'b1;
        end else begin
            rd_strobe_r <= 1'b0;
            if (stop_det) begin
                state_r <= ST_IDLE;
                ph_r <= PH_ADDR;
                sda_oe_n_r <= 1'b1;
                scl_oe_n_r <= 1'b1;
                if (ph_r == PH_RD && sent_r) begin
                    ck_valid_r <= 1'b1;
                end else if (ph_r == PH_CK || ph_r == PH_CKDONE) begin
                    ck_valid_r <= 1'b0;
                end
            end else if (start_det) begin
                state_r <= ST_RX;
                ph_r <= PH_ADDR;
                bitcnt_r <= 4'h0;
                sent_r <= 1'b0;
                sr_ok_r <= (state_r == ST_SR);
                sda_oe_n_r <= 1'b1;
            end else begin
                case (state_r)
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s2_r};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end
                        if (byte_done) begin
                            ack_r <= acc_w;
                            sda_oe_n_r <= ~acc_w;
                            state_r <= ST_ACK;
                            if (acc_w) begin
                                ph_r <= ph_dec_w;
                                sum_r <= (ph_r == PH_B1) ? shift_r : (sum_r ^ shift_r);
                                if (ph_r == PH_B1 && shift_r != GUARD_FIRST) begin
                                    rd_addr_r <= shift_r;
                                end
                                if (ph_r == PH_WREG) begin
                                    wreg_r <= shift_r;
                                end
                                if (ph_r == PH_WVAL) begin
                                    wval_r <= shift_r;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bitcnt_r <= 4'h0;
                            if (!ack_r) begin
                                state_r <= ST_IDLE;
                                sda_oe_n_r <= 1'b1;
                            end else if (hold_need) begin
                                state_r <= ST_HOLD;
                                scl_oe_n_r <= 1'b0;
                                sda_oe_n_r <= 1'b1;
                            end else if (!rd_phase) begin
                                state_r <= (ph_r == PH_SR) ? ST_SR : ST_RX;
                                sda_oe_n_r <= 1'b1;
                            end
                        end
                    end
                    ST_HOLD: begin
                        if (fill_s.ready) begin
                            state_r <= ST_RX;
                            scl_oe_n_r <= 1'b1;
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bitcnt_r <= bitcnt_r + 4'h1;
                            if (sda_oe_n_r && !sda_s2_r) begin
                                state_r <= ST_IDLE;
                            end
                        end
                        if (scl_fall) begin
                            if (bitcnt_r == BITS_PER_BYTE) begin
                                sda_oe_n_r <= 1'b1;
                                state_r <= ST_MACK;
                            end else begin
                                sda_oe_n_r <= tx_r[7];
                                tx_r <= {tx_r[6:0], 1'b1};
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            mack_r <= ~sda_s2_r;
                        end
                        if (scl_fall && !mack_r) begin
                            state_r <= ST_IDLE;
                        end
                    end
                    ST_SR: begin
                        if ((scl_rise && !sda_s2_r) || scl_fall) begin
                            state_r <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
                if (load_w) begin
                    state_r <= ST_TX;
                    bitcnt_r <= 4'h0;
                    sda_oe_n_r <= tx_load_w[7];
                    tx_r <= {tx_load_w[6:0], 1'b1};
                    if (ph_r == PH_RD) begin
                        rd_addr_r <= rd_addr_r + 8'h01;
                        rd_strobe_r <= 1'b1;
                        ck_r <= sent_r ? (ck_r ^ rd_data) : rd_data;
                        sent_r <= 1'b1;
                    end else if (ph_r == PH_CK) begin
                        ph_r <= PH_CKDONE;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_START_ADDR: assert property (
        start_det && !stop_det |=> state_r == ST_RX && ph_r == PH_ADDR && bitcnt_r == 4'h0)
        else $error("start did not open an address byte");
    AST_STOP_IDLE: assert property (
        stop_det |=> state_r == ST_IDLE && sda_oe_n_r && scl_oe_n_r ##1 state_r == ST_IDLE || start_det)
        else $error("stop did not idle the interface");
    AST_DRIVE_LOW_CLOCK: assert property (
        $fell(sda_oe_n_r) |-> !scl_s2_r && $past(!scl_s2_r))
        else $error("data driven low while clock high");
    AST_ACK_NINTH: assert property (
        byte_done && acc_w && !stop_det && !start_det |=> !sda_oe_n_r && state_r == ST_ACK)
        else $error("accepted byte not acknowledged");
    AST_GCALL_NACK: assert property (
        byte_done && ph_r == PH_ADDR && is_gcall |=> sda_oe_n_r)
        else $error("general call acknowledged");
    AST_TENBIT_NACK: assert property (
        byte_done && ph_r == PH_ADDR && is_tenbit |=> sda_oe_n_r)
        else $error("extended address acknowledged");
    AST_BUSY_NACK: assert property (
        byte_done && ph_r == PH_ADDR && busy_w |=> sda_oe_n_r [*2])
        else $error("address acknowledged during pending write");
    AST_BAD_SUM: assert property (
        byte_done && ph_r == PH_WSUM && shift_r != sum_r && !stop_det |=> sda_oe_n_r && ph_r == PH_WSUM)
        else $error("bad checksum accepted");
    AST_STRETCH: assert property (
        state_r == ST_ACK && scl_fall && ack_r && hold_need && !stop_det && !start_det
        |=> !scl_oe_n_r && state_r == ST_HOLD)
        else $error("clock not held for full write queue");
    AST_RD_INC: assert property (
        $rose(rd_strobe_r) |-> rd_addr_r == $past(rd_addr_r) + 8'h01)
        else $error("read address did not advance");
    AST_SR_COLL: assert property (
        state_r == ST_SR && scl_fall && !stop_det && !start_det |=> state_r == ST_IDLE)
        else $error("repeated start collision missed");
endmodule

// File: word_fifo.sv
// Synchronous word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
)(
    input wire logic clk,
    input wire logic rst_n,
    stream_if.snk fill,
    stream_if.src drain
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    wire push_w = fill.valid & fill.ready;
    wire pop_w = drain.valid & drain.ready;

    assign fill.ready = (count_r != FULL_COUNT);
    assign drain.valid = (count_r != '0);
    assign drain.data = mem[rd_ptr_r];

    always_ff @(posedge clk) begin
        if (push_w) begin
            mem[wr_ptr_r] <= fill.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop_w) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if (push_w && !pop_w) begin
                count_r <= count_r + 1'b1;
            end else if (pop_w && !push_w) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
